// [dv/tte_pmu_model.sv]
// Integrator tie-off source and performance counter model
`timescale 1ns/100ps
`default_nettype none
module tte_pmu_model (
    input  wire logic        ref_clk_i,
    input  wire logic        clr_i,
    input  wire logic [5:0]  ev_i,
    input  wire logic        half_clk_i,
    input  wire logic        override_i,
    input  wire logic        policy_i,
    output logic             scan_hold_o,
    output logic             sec_dbg_o,
    output logic [5:0][7:0]  cnt_o
);
    assign scan_hold_o = half_clk_i;
    assign sec_dbg_o = policy_i & ~override_i;
    // Eight bits suffice for the short windows; longer runs would wrap
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < 6; i++) begin
            cnt_o[i] <= clr_i ? 8'h00 : cnt_o[i] + {7'h00, ev_i[i]};
        end
    end
endmodule
`default_nettype wire

// [dv/tte_top_tb_top.sv]
// Register, tie-off and event tests of the tie-off block
`timescale 1ns/100ps
`default_nettype none
module tte_top_tb_top;
    logic clk = 1'b0, rstn = 1'b0, cw = 1'b1, tb = 1'b0, ovr = 1'b0, bd = 1'b0, norm = 1'b1;
    logic rt = 1'b0, wt = 1'b0, ra = 1'b0, wa = 1'b0, sec = 1'b0, ob = 1'b0, ub = 1'b0;
    logic wr = 1'b0, rd = 1'b0, ns = 1'b0, half = 1'b0, pol = 1'b0, clr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, d;
    logic sh, sd, cgb, bar, sho, anf;
    logic [5:0] ev;
    logic [5:0][7:0] cnt;
    logic [7:0] exp_cnt [6] = '{8'h80, 8'h02, 8'h0d, 8'h06, 8'h04, 8'h01};
    int fail_count = 0, tests_run = 0;
    always #4 clk = ~clk;
    tte_top dut (.ref_clk_i(clk), .rstn_i(rstn), .cfg_coherent_walk_i(cw),
        .test_gate_bypass_i(tb), .integ_sec_override_i(ovr), .barrier_disable_i(bd),
        .scan_hold_i(sh), .cfg_normalize_i(norm), .secure_debug_en_i(sd), .rd_txn_i(rt),
        .wr_txn_i(wt), .rd_alloc_i(ra), .wr_alloc_i(wa), .txn_secure_i(sec),
        .own_barrier_req_i(ob), .up_barrier_i(ub), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_nonsecure_i(ns), .reg_rdata_o(rdat),
        .clk_gate_bypass_o(cgb), .barrier_o(bar), .scan_hold_o(sho),
        .aux_normalize_flag_o(anf), .event_clk_o(ev[0]), .every_64_clock_event_o(ev[1]),
        .event_wr_access_o(ev[2]), .event_rd_access_o(ev[3]), .event_wr_alloc_o(ev[4]),
        .event_rd_alloc_o(ev[5]));
    tte_pmu_model pmu (.ref_clk_i(clk), .clr_i(clr), .ev_i(ev), .half_clk_i(half),
        .override_i(ovr), .policy_i(pol), .scan_hold_o(sh), .sec_dbg_o(sd), .cnt_o(cnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v, input logic n);
        @(posedge clk);
        {wr, addr, wd, ns} <= {1'b1, a, v, n};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic reg_rd(input logic [3:0] a, input logic n);
        @(posedge clk);
        {rd, addr, ns} <= {1'b1, a, n};
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdat;
    endtask
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, anf}, 32'h1);
        reg_rd(4'h4, 1'b0);
        chk({31'h0, d[0]}, 32'h1);
        reg_rd(4'h0, 1'b0);
        chk({31'h0, d[14]}, 32'h1);
        reg_wr(4'h8, 32'h0000_005a, 1'b1);
        reg_rd(4'h8, 1'b0);
        chk(d, 32'h0);
        ovr <= 1'b1;
        reg_wr(4'h8, 32'h0000_00a5, 1'b1);
        reg_rd(4'h8, 1'b1);
        chk(d, 32'h0000_00a5);
        reg_rd(4'hc, 1'b1);
        chk(d, 32'h0);
        ovr <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            {bd, ob, ub, tb, half} <= {k[2], k[1], k[0], k[0], k[1]};
            repeat (3) @(posedge clk);
            chk({31'h0, bar}, {31'h0, k[0] | (k[1] & ~k[2])});
            chk({31'h0, cgb}, {31'h0, k[0]});
            chk({31'h0, sho}, {31'h0, k[1]});
        end
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        // Secure writes 40..44 are dropped while the trace policy is low
        for (int i = 0; i < 128; i++) begin
            wt <= (i < 10) || (i >= 40 && i < 45) || (i >= 50 && i < 53);
            wa <= i < 4;
            rt <= i >= 20 && i < 26;
            ra <= i == 20;
            sec <= i >= 40;
            pol <= i >= 50;
            @(posedge clk);
        end
        @(posedge clk);
        for (int j = 0; j < 6; j++) begin
            chk({24'h0, cnt[j]}, {24'h0, exp_cnt[j]});
        end
        end_sim();
    end
endmodule
`default_nettype wire

// [src/tte_params.svh]
// Constants and contract list for the tie-off and event block
// Contract
// - Report coherent-walk tie-off in identification register
// - Coherent-walk tie-off never alters access generation
// - Test bypass high bypasses clock gates
// - Override lets Non-secure access integration registers
// - Barrier disable stops own barriers, still forwards
// - Normalize flag resets to its tie-off value (code clears it at reset, loads the tie-off in the first cycle after)
// - Every-clock event and every-64th-clock event
// - One write event per write transaction
// - One read event per read transaction
// - Write allocation event per write TLB allocation
// - Read allocation event per read TLB allocation
// - Secure events counted only with debug enable
`ifndef TTE_PARAMS_SVH
`define TTE_PARAMS_SVH
`define TTE_ADDR_W        4
`define TTE_OFF_IDR0      4'h0
`define TTE_OFF_AUX       4'h4
`define TTE_OFF_INTEG     4'h8
`define TTE_IDR0_CTTW_BIT 14
`define TTE_AUX_NORM_BIT  0
`define TTE_CLK64_DIV     64
`define TTE_CLK64_W       6
`endif

// [src/tte_pkg.sv]
// Types for the tie-off and event block
package tte_pkg;
    typedef logic [31:0] tte_word_t;
endpackage

// [src/tte_top.sv]
// Tie-off handling and performance event outputs of one translation buffer unit
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "tte_params.svh"
`default_nettype none
module tte_top
    import tte_pkg::*;
(
    input  wire logic                    ref_clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    cfg_coherent_walk_i,
    input  wire logic                    test_gate_bypass_i,
    input  wire logic                    integ_sec_override_i,
    input  wire logic                    barrier_disable_i,
    input  wire logic                    scan_hold_i,
    input  wire logic                    cfg_normalize_i,
    input  wire logic                    secure_debug_en_i,
    input  wire logic                    rd_txn_i,
    input  wire logic                    wr_txn_i,
    input  wire logic                    rd_alloc_i,
    input  wire logic                    wr_alloc_i,
    input  wire logic                    txn_secure_i,
    input  wire logic                    own_barrier_req_i,
    input  wire logic                    up_barrier_i,
    input  wire logic [`TTE_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic                    reg_nonsecure_i,
    output logic [31:0]                  reg_rdata_o,
    output logic                         clk_gate_bypass_o,
    output logic                         barrier_o,
    output logic                         scan_hold_o,
    output logic                         aux_normalize_flag_o,
    output logic                         event_clk_o,
    output logic                         every_64_clock_event_o,
    output logic                         event_wr_access_o,
    output logic                         event_rd_access_o,
    output logic                         event_wr_alloc_o,
    output logic                         event_rd_alloc_o
);
    logic [`TTE_CLK64_W-1:0] div_reg;
    logic                    started_reg;
    logic                    norm_reg;
    tte_word_t               integ_reg;
    tte_word_t               rdata_next;
    tte_word_t               idr0_word;
    wire logic               cnt_ok;
    wire logic               integ_ok;
    wire logic               wr_aux;
    wire logic               wr_integ;
    wire logic               tick64;

    assign cnt_ok   = secure_debug_en_i | ~txn_secure_i;
    assign integ_ok = ~reg_nonsecure_i | integ_sec_override_i;
    assign wr_aux   = reg_wr_i & (reg_addr_i == `TTE_OFF_AUX);
    assign wr_integ = reg_wr_i & (reg_addr_i == `TTE_OFF_INTEG) & integ_ok;
    assign tick64   = started_reg & (div_reg == '0);

    always_comb begin
        idr0_word = '0;
        idr0_word[`TTE_IDR0_CTTW_BIT] = cfg_coherent_walk_i;
    end

    // Unmapped or refused reads return zero
    always_comb begin
        rdata_next = '0;
        case (reg_addr_i)
            `TTE_OFF_IDR0: rdata_next = idr0_word;
            `TTE_OFF_AUX: rdata_next[`TTE_AUX_NORM_BIT] = norm_reg;
            `TTE_OFF_INTEG: rdata_next = integ_ok ? integ_reg : '0;
            default: rdata_next = '0;
        endcase
    end

    // normalize flag cleared at reset, loaded from tie-off in the first cycle after reset
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            norm_reg <= 1'b0;
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
            if (!started_reg)
                norm_reg <= cfg_normalize_i;
            else if (wr_aux)
                norm_reg <= reg_wdata_i[`TTE_AUX_NORM_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            integ_reg <= '0;
            reg_rdata_o <= '0;
            div_reg <= '0;
        end else begin
            if (wr_integ)
                integ_reg <= reg_wdata_i;
            reg_rdata_o <= reg_rd_i ? rdata_next : '0;
            if (started_reg)
                div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            event_clk_o <= 1'b0;
            every_64_clock_event_o <= 1'b0;
            event_wr_access_o <= 1'b0;
            event_rd_access_o <= 1'b0;
            event_wr_alloc_o <= 1'b0;
            event_rd_alloc_o <= 1'b0;
            clk_gate_bypass_o <= 1'b0;
            barrier_o <= 1'b0;
            scan_hold_o <= 1'b0;
            aux_normalize_flag_o <= 1'b0;
        end else begin
            event_clk_o <= 1'b1;
            every_64_clock_event_o <= tick64;
            event_wr_access_o <= wr_txn_i & cnt_ok;
            event_rd_access_o <= rd_txn_i & cnt_ok;
            event_wr_alloc_o <= wr_alloc_i & wr_txn_i & cnt_ok;
            event_rd_alloc_o <= rd_alloc_i & rd_txn_i & cnt_ok;
            clk_gate_bypass_o <= test_gate_bypass_i;
            barrier_o <= up_barrier_i | (own_barrier_req_i & ~barrier_disable_i);
            scan_hold_o <= scan_hold_i;
            aux_normalize_flag_o <= norm_reg;
        end
    end

    // coherent walk input reaches only the identification word

    a_rd_event_one: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rd_txn_i & cnt_ok |=> event_rd_access_o) else $error("read event missing");
    a_wr_event_one: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_txn_i & cnt_ok |=> event_wr_access_o) else $error("write event missing");
    a_secure_blocked: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        txn_secure_i & !secure_debug_en_i |=> !event_rd_access_o && !event_wr_access_o)
        else $error("secure event counted");
    a_wr_alloc_evt: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        event_wr_alloc_o |-> $past(wr_alloc_i) && event_wr_access_o)
        else $error("bad write alloc event");
    a_rd_alloc_evt: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        event_rd_alloc_o |-> $past(rd_alloc_i) && event_rd_access_o)
        else $error("bad read alloc event");
    a_clk64_period: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        every_64_clock_event_o |=> !every_64_clock_event_o [*8])
        else $error("clk64 too often");
    a_clk64_seen: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        every_64_clock_event_o |-> ##64 every_64_clock_event_o)
        else $error("clk64 period wrong");
    a_barrier_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        barrier_disable_i & !up_barrier_i |=> !barrier_o)
        else $error("own barrier while disabled");
    a_idr_cttw: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == `TTE_OFF_IDR0 |=>
        reg_rdata_o[`TTE_IDR0_CTTW_BIT] == $past(cfg_coherent_walk_i))
        else $error("cttw not reported");
    a_integ_refuse: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == `TTE_OFF_INTEG && reg_nonsecure_i && !integ_sec_override_i
        |=> reg_rdata_o == '0) else $error("integ read leaked");
    a_bypass_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ##1 clk_gate_bypass_o == $past(test_gate_bypass_i))
        else $error("bypass mismatch");
    a_norm_reset: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(started_reg) |-> norm_reg == $past(cfg_normalize_i))
        else $error("normalize not loaded");

    a_clk_evt_on: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1
        |=> event_clk_o)
        else $error("clock event missing");

    a_clk64_tick: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        tick64
        |=> every_64_clock_event_o)
        else $error("clk64 tick lost");

    a_clk64_only: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        every_64_clock_event_o
        |-> $past(tick64))
        else $error("clk64 without tick");

    a_div_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        started_reg
        |=> div_reg == $past(div_reg) + 1'b1)
        else $error("divider skipped");

    a_rd_no_spur: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        event_rd_access_o
        |-> $past(rd_txn_i))
        else $error("read event without read");

    a_wr_no_spur: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        event_wr_access_o
        |-> $past(wr_txn_i))
        else $error("write event without write");

    a_rd_pulse_end: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !rd_txn_i
        |=> !event_rd_access_o)
        else $error("read event stretched");

    a_wr_pulse_end: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !wr_txn_i
        |=> !event_wr_access_o)
        else $error("write event stretched");

    a_wral_need: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_alloc_i & wr_txn_i & cnt_ok
        |=> event_wr_alloc_o)
        else $error("write alloc event missing");

    a_rdal_need: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rd_alloc_i & rd_txn_i & cnt_ok
        |=> event_rd_alloc_o)
        else $error("read alloc event missing");

    a_wral_end: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !wr_alloc_i
        |=> !event_wr_alloc_o)
        else $error("write alloc stretched");

    a_rdal_end: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !rd_alloc_i
        |=> !event_rd_alloc_o)
        else $error("read alloc stretched");

    a_secure_alloc: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        txn_secure_i & !secure_debug_en_i
        |=> !event_wr_alloc_o && !event_rd_alloc_o)
        else $error("secure alloc counted");

    a_sec_wr_count: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        txn_secure_i & secure_debug_en_i & wr_txn_i
        |=> event_wr_access_o)
        else $error("allowed secure write lost");

    a_sec_rd_count: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        txn_secure_i & secure_debug_en_i & rd_txn_i
        |=> event_rd_access_o)
        else $error("allowed secure read lost");

    a_barrier_fwd: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        up_barrier_i
        |=> barrier_o)
        else $error("barrier not forwarded");

    a_barrier_own: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        own_barrier_req_i & !barrier_disable_i
        |=> barrier_o)
        else $error("own barrier missing");

    a_barrier_idle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !up_barrier_i & !own_barrier_req_i
        |=> !barrier_o)
        else $error("barrier from nowhere");

    a_scan_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1
        |=> scan_hold_o == $past(scan_hold_i))
        else $error("scan hold mismatch");

    a_idr_other: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == `TTE_OFF_IDR0
        |=> reg_rdata_o[31:15] == '0 && reg_rdata_o[13:0] == '0)
        else $error("coherent walk leaked");

    // read data only after a read
    a_rd_idle_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !reg_rd_i
        |=> reg_rdata_o == '0)
        else $error("read data without read");

    a_integ_wr_no: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == `TTE_OFF_INTEG && reg_nonsecure_i && !integ_sec_override_i
        |=> integ_reg == $past(integ_reg))
        else $error("refused write landed");

    a_integ_wr_ok: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == `TTE_OFF_INTEG && integ_ok
        |=> integ_reg == $past(reg_wdata_i))
        else $error("integ write lost");

    a_integ_rd_ok: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == `TTE_OFF_INTEG && integ_ok
        |=> reg_rdata_o == $past(integ_reg))
        else $error("integ read wrong");

    a_aux_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == `TTE_OFF_AUX
        |=> reg_rdata_o[0] == $past(norm_reg) && reg_rdata_o[31:1] == '0)
        else $error("aux read wrong");

    a_aux_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        started_reg && wr_aux
        |=> norm_reg == $past(reg_wdata_i[0]))
        else $error("aux write lost");

    a_norm_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        started_reg && !wr_aux
        |=> $stable(norm_reg))
        else $error("normalize flag drifted");

    a_norm_out: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1
        |=> aux_normalize_flag_o == $past(norm_reg))
        else $error("normalize output mismatch");

    c_rd_alloc: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) event_rd_alloc_o);
    c_wr_alloc: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) event_wr_alloc_o);
    c_clk64: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) every_64_clock_event_o);
    c_integ_ns: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_integ && reg_nonsecure_i);
endmodule
`default_nettype wire
